// [verilog/oss_pkg.sv]
// constants and types for the oscillator source selection block
// Operation
// - four-times multiplier fed by primary or fast RC
// - instruction rate is oscillator rate halved
// - select 111: fast RC divide-by-n, erased default
// - select 110: fast RC divided by sixteen
// - select 101: low-power RC oscillator
// - select 100: secondary oscillator
// - mode 10/01/00 for 010 direct; mode 01/00 only for 011 multiplied
// - select 001: fast RC divide-by-n then multiplier
// - select 000: undivided fast RC
// - config bit sets output pin when no crystal
// - crystal sources wait 1024 oscillator periods
// - multiplied clock held off 1.5 ms lock
package oss_pkg;

    // ********************************************************
    // select field codes
    // ********************************************************
    localparam logic [2:0] OSS_SEL_FAST_RC        = 3'h0;
    localparam logic [2:0] OSS_SEL_FAST_RC_MULT   = 3'h1;
    localparam logic [2:0] OSS_SEL_PRIMARY        = 3'h2;
    localparam logic [2:0] OSS_SEL_PRIMARY_MULT   = 3'h3;
    localparam logic [2:0] OSS_SEL_SECONDARY      = 3'h4;
    localparam logic [2:0] OSS_SEL_LOW_POWER_RC   = 3'h5;
    localparam logic [2:0] OSS_SEL_FAST_RC_DIV16  = 3'h6;
    localparam logic [2:0] OSS_SEL_FAST_RC_DIVN   = 3'h7;

    // ********************************************************
    // primary mode field codes
    // ********************************************************
    localparam logic [1:0] OSS_PM_EXT_CLOCK       = 2'h0;
    localparam logic [1:0] OSS_PM_MEDIUM_XTAL     = 2'h1;
    localparam logic [1:0] OSS_PM_HIGH_XTAL       = 2'h2;
    localparam logic [1:0] OSS_PM_OFF             = 2'h3;

    // ********************************************************
    // values after reset (erased configuration)
    // ********************************************************
    localparam logic [2:0] OSS_SEL_RESET          = 3'h7;
    localparam logic [1:0] OSS_PM_RESET           = 2'h3;
    localparam logic [2:0] OSS_DIVN_RESET         = 3'h0;
    localparam logic       OSS_PIN_FN_RESET       = 1'h0;

    // ********************************************************
    // ratios and timing
    // ********************************************************
    localparam int         OSS_MULT_SHIFT         = 2;
    localparam logic [7:0] OSS_DIV16_MASK         = 8'h0f;
    localparam logic [10:0] OSS_OST_PERIODS       = 11'h400;
    localparam int         OSS_CLK_PERIOD_PS      = 10000;
    localparam int         OSS_LOCK_TIME_PS       = 1500000000;
    localparam int         OSS_LOCK_CYCLES        =
        (OSS_LOCK_TIME_PS + OSS_CLK_PERIOD_PS - 1) / OSS_CLK_PERIOD_PS;

    // ********************************************************
    // types
    // ********************************************************
    typedef enum logic [3:0] {
        OSS_ST_CAPTURE = 4'h1,
        OSS_ST_STARTUP = 4'h2,
        OSS_ST_LOCK    = 4'h4,
        OSS_ST_RUN     = 4'h8
    } oss_state_type;

    typedef struct packed {
        logic [2:0] div_n;
        logic       osc_out_pin_function_bit;
        logic [1:0] primary_osc_mode_field;
        logic [2:0] initial_osc_select_field;
    } oss_config_type;

    typedef struct packed {
        logic fast_rc;
        logic low_power_rc;
        logic secondary;
        logic primary;
    } oss_ticks_type;

endpackage

// [verilog/oss_source_select.sv]
// oscillator source selection, start-up and lock hold-off, rate outputs
module oss_source_select #(
    parameter int LOCK_CYCLES = oss_pkg::OSS_LOCK_CYCLES,
    parameter int PERIOD_W    = 16
) (
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    reset,
    // configuration fields and oscillator ticks
    input  wire oss_pkg::oss_config_type cfg,
    input  wire oss_pkg::oss_ticks_type  src_ticks,
    // general purpose drive for the output pin
    input  wire logic                    gpio_out,
    input  wire logic                    gpio_oe,
    // clock outputs
    output logic                         sys_osc_tick,
    output logic                         instruction_cycle_tick,
    output logic                         clock_ready,
    output logic [2:0]                   active_select,
    // oscillator pins
    output logic                         crystal_drive_en,
    output logic                         osc_output_pin_o,
    output logic                         osc_output_pin_oe
);

    // ********************************************************
    // state
    // ********************************************************
    oss_pkg::oss_state_type  state_q;
    oss_pkg::oss_state_type  state_d;
    oss_pkg::oss_config_type cfg_q;
    logic [7:0]              div_cnt_q;
    logic [10:0]             ost_cnt_q;
    logic [31:0]             lock_cnt_q;
    logic [PERIOD_W-1:0]     per_cnt_q;
    logic [PERIOD_W-1:0]     per_q;
    logic [PERIOD_W-1:0]     ph_cnt_q;
    logic                    phase_q;
    logic                    sys_tick_q;
    logic                    instr_tick_q;
    logic                    ready_q;
    logic                    xtal_q;
    logic                    pin_o_q;
    logic                    pin_oe_q;
    logic                    cap_done_q;
    logic [2:0]              active_q;

    // ********************************************************
    // configuration decode
    // ********************************************************
    wire [2:0] sel = cfg_q.initial_osc_select_field;
    wire [1:0] pm  = cfg_q.primary_osc_mode_field;

    wire pm_crystal  = (pm == oss_pkg::OSS_PM_HIGH_XTAL) ||
                       (pm == oss_pkg::OSS_PM_MEDIUM_XTAL);
    wire pm_mult_ok  = (pm == oss_pkg::OSS_PM_MEDIUM_XTAL) ||
                       (pm == oss_pkg::OSS_PM_EXT_CLOCK);
    wire prim_direct = (sel == oss_pkg::OSS_SEL_PRIMARY) &&
                       (pm != oss_pkg::OSS_PM_OFF);
    wire prim_mult   = (sel == oss_pkg::OSS_SEL_PRIMARY_MULT) && pm_mult_ok;
    wire prim_bad    = ((sel == oss_pkg::OSS_SEL_PRIMARY) ||
                        (sel == oss_pkg::OSS_SEL_PRIMARY_MULT)) &&
                       !prim_direct && !prim_mult;
    wire fast_mult   = (sel == oss_pkg::OSS_SEL_FAST_RC_MULT);
    wire use_mult    = fast_mult || prim_mult;
    wire drives_xtal = (prim_direct || prim_mult) && pm_crystal;
    wire needs_ost   = drives_xtal || (sel == oss_pkg::OSS_SEL_SECONDARY);

    // ********************************************************
    // fast RC dividers
    // ********************************************************
    wire [7:0] divn_mask  = (8'h01 << cfg_q.div_n) - 8'h01;
    wire       divn_tick  = src_ticks.fast_rc &&
                            ((div_cnt_q & divn_mask) == divn_mask);
    wire       div16_tick = src_ticks.fast_rc &&
                            ((div_cnt_q & oss_pkg::OSS_DIV16_MASK) ==
                             oss_pkg::OSS_DIV16_MASK);

    // ********************************************************
    // base source selection, before the multiplier
    // ********************************************************
    wire base_tick =
        (sel == oss_pkg::OSS_SEL_FAST_RC_DIVN)  ? divn_tick :
        (sel == oss_pkg::OSS_SEL_FAST_RC_DIV16) ? div16_tick :
        (sel == oss_pkg::OSS_SEL_LOW_POWER_RC)  ? src_ticks.low_power_rc :
        (sel == oss_pkg::OSS_SEL_SECONDARY)     ? src_ticks.secondary :
        (prim_direct || prim_mult)              ? src_ticks.primary :
        fast_mult                               ? divn_tick :
        src_ticks.fast_rc;

    // ********************************************************
    // four-times multiplier: measure source period, emit quarters
    // ********************************************************
    wire [PERIOD_W-1:0] per_sum = per_cnt_q + PERIOD_W'(1);
    wire [PERIOD_W-1:0] slice_raw = per_q >> oss_pkg::OSS_MULT_SHIFT;
    wire [PERIOD_W-1:0] slice =
        (slice_raw == '0) ? PERIOD_W'(1) : slice_raw;
    wire                ph_end = (ph_cnt_q == slice - PERIOD_W'(1));
    wire                mult_tick = base_tick || ph_end;
    wire                sel_tick  = use_mult ? mult_tick : base_tick;

    // ********************************************************
    // start-up and lock hold-off
    // ********************************************************
    wire ost_done  = base_tick &&
                     (ost_cnt_q == oss_pkg::OSS_OST_PERIODS - 11'h001);
    wire lock_done = (lock_cnt_q == 32'(LOCK_CYCLES - 1));

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            // decide one cycle after capture, from the held fields
            oss_pkg::OSS_ST_CAPTURE: begin
                if (cap_done_q && needs_ost) begin
                    state_d = oss_pkg::OSS_ST_STARTUP;
                end else if (cap_done_q && use_mult) begin
                    state_d = oss_pkg::OSS_ST_LOCK;
                end else if (cap_done_q) begin
                    state_d = oss_pkg::OSS_ST_RUN;
                end
            end
            oss_pkg::OSS_ST_STARTUP: begin
                if (ost_done) begin
                    state_d = use_mult ? oss_pkg::OSS_ST_LOCK : oss_pkg::OSS_ST_RUN;
                end
            end
            oss_pkg::OSS_ST_LOCK: begin
                if (lock_done) begin
                    state_d = oss_pkg::OSS_ST_RUN;
                end
            end
            oss_pkg::OSS_ST_RUN: begin
                state_d = oss_pkg::OSS_ST_RUN;
            end
            default: begin
                state_d = oss_pkg::OSS_ST_CAPTURE;
            end
        endcase
    end

    wire running   = (state_q == oss_pkg::OSS_ST_RUN);
    wire capturing = (state_q == oss_pkg::OSS_ST_CAPTURE);

    // ********************************************************
    // output pin function
    // ********************************************************
    wire pin_o_d  = drives_xtal ? 1'b0 :
                    cfg_q.osc_out_pin_function_bit ? phase_q : gpio_out;
    wire pin_oe_d = drives_xtal ? 1'b0 :
                    cfg_q.osc_out_pin_function_bit ? running : gpio_oe;

    // ********************************************************
    // registers
    // ********************************************************
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q    <= oss_pkg::OSS_ST_CAPTURE;
            cap_done_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            cap_done_q <= 1'b1;
        end
    end

    // fields caught once after reset release, held until next reset
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cfg_q.initial_osc_select_field <= oss_pkg::OSS_SEL_RESET;
            cfg_q.primary_osc_mode_field   <= oss_pkg::OSS_PM_RESET;
            cfg_q.osc_out_pin_function_bit <= oss_pkg::OSS_PIN_FN_RESET;
            cfg_q.div_n                    <= oss_pkg::OSS_DIVN_RESET;
        end else if (capturing && !cap_done_q) begin
            cfg_q <= cfg;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            div_cnt_q <= 8'h00;
        end else if (src_ticks.fast_rc) begin
            div_cnt_q <= div_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ost_cnt_q <= 11'h000;
        end else if (state_q == oss_pkg::OSS_ST_STARTUP && base_tick) begin
            ost_cnt_q <= ost_cnt_q + 11'h001;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            lock_cnt_q <= 32'h0000_0000;
        end else if (state_q == oss_pkg::OSS_ST_LOCK) begin
            lock_cnt_q <= lock_cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            per_cnt_q <= '0;
            per_q     <= '0;
        end else if (base_tick) begin
            per_cnt_q <= '0;
            per_q     <= per_sum;
        end else if (per_cnt_q != '1) begin
            per_cnt_q <= per_sum;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ph_cnt_q <= '0;
        end else if (base_tick || ph_end) begin
            ph_cnt_q <= '0;
        end else begin
            ph_cnt_q <= ph_cnt_q + PERIOD_W'(1);
        end
    end

    // system tick and halved instruction tick only once running
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sys_tick_q   <= 1'b0;
            instr_tick_q <= 1'b0;
            phase_q      <= 1'b0;
        end else begin
            sys_tick_q   <= running && sel_tick;
            instr_tick_q <= running && sel_tick && phase_q;
            if (running && sel_tick) begin
                phase_q <= !phase_q;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ready_q  <= 1'b0;
            xtal_q   <= 1'b0;
            pin_o_q  <= 1'b0;
            pin_oe_q <= 1'b0;
            active_q <= oss_pkg::OSS_SEL_RESET;
        end else begin
            active_q <= prim_bad ? oss_pkg::OSS_SEL_FAST_RC : sel;
            ready_q  <= running;
            xtal_q   <= !capturing && drives_xtal;
            pin_o_q  <= !capturing && pin_o_d;
            pin_oe_q <= !capturing && pin_oe_d;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign sys_osc_tick           = sys_tick_q;
    assign instruction_cycle_tick = instr_tick_q;
    assign clock_ready            = ready_q;
    assign active_select          = active_q;
    assign crystal_drive_en       = xtal_q;
    assign osc_output_pin_o       = pin_o_q;
    assign osc_output_pin_oe      = pin_oe_q;

endmodule

// [tb/oss_source_select_properties.sv]
// port assertions for the oscillator source selection block
module oss_source_select_properties #(
    parameter int LOCK_CYCLES = 20,
    parameter int PERIOD_W    = 16
) (
    // clock and reset
    input wire logic                    mclk,
    input wire logic                    reset,
    // inputs
    input wire oss_pkg::oss_config_type cfg,
    input wire oss_pkg::oss_ticks_type  src_ticks,
    input wire logic                    gpio_out,
    input wire logic                    gpio_oe,
    // outputs
    input wire logic                    sys_osc_tick,
    input wire logic                    instruction_cycle_tick,
    input wire logic                    clock_ready,
    input wire logic [2:0]              active_select,
    input wire logic                    crystal_drive_en,
    input wire logic                    osc_output_pin_o,
    input wire logic                    osc_output_pin_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // helper logic
    // ****************************************
    logic [11:0]             cnt_q;
    logic                    par_q;
    oss_pkg::oss_config_type cap_q;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_q <= 12'h000;
            par_q <= 1'b0;
            cap_q <= '0;
        end else begin
            if (cnt_q != 12'hfff) cnt_q <= cnt_q + 12'h001;
            if (cnt_q == 12'h000) cap_q <= cfg;
            if (sys_osc_tick) par_q <= !par_q;
        end
    end
    wire [2:0] sel    = cap_q.initial_osc_select_field;
    wire [1:0] pm     = cap_q.primary_osc_mode_field;
    wire       pxtal  = (sel == 3'h2 && (pm == 2'h1 || pm == 2'h2)) || (sel == 3'h3 && pm == 2'h1);
    wire       xtal   = pxtal || sel == 3'h4;
    wire       mult   = sel == 3'h1 || (sel == 3'h3 && !pm[1]);
    wire       nowait = sel == 3'h0 || sel >= 3'h5 || (sel == 3'h2 && pm == 2'h0);
    wire       fn     = cap_q.osc_out_pin_function_bit;
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    AST_INSTR_HALF: assert property ((sys_osc_tick || instruction_cycle_tick) |->
        sys_osc_tick && instruction_cycle_tick == par_q) else $error("instruction tick phase");
    AST_NO_TICK_EARLY: assert property (!clock_ready |-> !sys_osc_tick)
        else $error("tick before ready");
    AST_READY_STANDS: assert property (clock_ready |=> clock_ready)
        else $error("ready dropped");
    AST_READY_NO_WAIT: assert property ((cnt_q == 12'h003 && nowait) |-> clock_ready)
        else $error("no-wait source late");
    AST_XTAL_WAIT: assert property ((xtal && cnt_q < 12'h400) |-> !clock_ready)
        else $error("crystal start-up too short");
    AST_LOCK_HOLD: assert property ((mult && cnt_q <= LOCK_CYCLES) |-> !clock_ready)
        else $error("lock hold-off too short");
    AST_CRYSTAL_PIN: assert property (cnt_q > 12'h003 |-> crystal_drive_en == pxtal &&
        !(crystal_drive_en && osc_output_pin_oe)) else $error("crystal pin ownership");
    AST_CLOCK_OUT_PIN: assert property ((clock_ready && !pxtal && fn) |-> osc_output_pin_oe)
        else $error("clock out pin not driven");
    AST_GPIO_PIN: assert property ((clock_ready && !pxtal && !fn) |->
        osc_output_pin_oe == $past(gpio_oe) && osc_output_pin_o == $past(gpio_out))
        else $error("pin does not follow gpio");
    AST_SELECT_MAP: assert property ((cnt_q >= 12'h002 && sel[2:1] != 2'b01) |->
        active_select == sel) else $error("select not honoured");
    cover property (clock_ready && xtal);
    cover property (clock_ready && mult);
    cover property (instruction_cycle_tick);
endmodule

// [tb/oss_osc_model.sv]
// free running pulse sources standing in for the oscillators
module oss_osc_model #(
    parameter int P_FAST = 2,
    parameter int P_LOW_POWER_RC_MODE = 7,
    parameter int P_SEC  = 3,
    parameter int P_PRI  = 4
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              reset,
    // one pulse per oscillator period
    output oss_pkg::oss_ticks_type ticks
);
    timeunit 1ns;
    timeprecision 100ps;
    int n_q;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) n_q <= 0;
        else n_q <= n_q + 1;
    end
    assign ticks.fast_rc      = (n_q % P_FAST) == 0;
    assign ticks.low_power_rc = (n_q % P_LOW_POWER_RC_MODE) == 0;
    assign ticks.secondary    = (n_q % P_SEC) == 0;
    assign ticks.primary      = (n_q % P_PRI) == 0;
endmodule

// [tb/test_oss_source_select.sv]
// self-checking bench for the oscillator source selection block
module test_oss_source_select;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LOCK = 20;
    logic                    mclk, reset, gpio_out, gpio_oe, sys_osc_tick, clock_ready;
    logic                    instruction_cycle_tick, crystal_drive_en, pin_o, pin_oe;
    logic [2:0]              active_select;
    oss_pkg::oss_config_type cfg;
    oss_pkg::oss_ticks_type  src_ticks;
    int                      err_total, n_checks, ready_at, n_sys, n_ins, n_pin;
    oss_source_select #(.LOCK_CYCLES(LOCK)) uut (.mclk(mclk), .reset(reset), .cfg(cfg),
        .src_ticks(src_ticks), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .sys_osc_tick(sys_osc_tick), .instruction_cycle_tick(instruction_cycle_tick),
        .clock_ready(clock_ready), .active_select(active_select),
        .crystal_drive_en(crystal_drive_en), .osc_output_pin_o(pin_o),
        .osc_output_pin_oe(pin_oe));
    oss_osc_model u_osc (.mclk(mclk), .reset(reset), .ticks(src_ticks));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic near(input int got, input int exp);
        n_checks++;
        if (got > exp + 4 || got < exp - 4) begin
            err_total++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic start(input logic [2:0] sel, input logic [1:0] pm, input logic fn,
                         input logic [2:0] dn);
        int i;
        @(posedge mclk);
        #1 reset = 1'b1;
        cfg = '{dn, fn, pm, sel};
        repeat (2) @(posedge mclk);
        #1;
        check(16'(active_select), 16'h0007);
        reset = 1'b0;
        for (i = 0; i < 20000 && clock_ready !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        ready_at = i;
        if (i == 20000) begin
            err_total++;
            print_verdict();
        end
    endtask
    task automatic measure;
        logic last;
        n_sys = 0;
        n_ins = 0;
        n_pin = 0;
        last = pin_o;
        repeat (640) begin
            @(posedge mclk);
            #1;
            n_sys += int'(sys_osc_tick === 1'b1);
            n_ins += int'(instruction_cycle_tick === 1'b1);
            n_pin += int'(pin_o !== last);
            last = pin_o;
        end
    endtask
    task automatic sc_internal;
        int sl[4] = '{0, 6, 7, 5};
        int rt[4] = '{320, 20, 80, 91};
        for (int k = 0; k < 4; k++) begin
            start(3'(sl[k]), 2'h2, 1'b0, 3'h2);
            check(16'(ready_at), 16'h0003);
            check(16'(active_select), 16'(sl[k]));
            measure();
            near(n_sys, rt[k]);
            near(n_ins, rt[k] / 2);
        end
    endtask
    task automatic sc_sources;
        int sl[9] = '{2, 2, 2, 2, 3, 3, 3, 1, 4};
        int pm[9] = '{0, 2, 1, 3, 1, 0, 2, 3, 0};
        int mn[9] = '{3, 4096, 4096, 3, 4096 + LOCK, LOCK, 3, LOCK, 3072};
        int rt[9] = '{160, 160, 160, 320, 640, 640, 320, 640, 213};
        int ac[9] = '{2, 2, 2, 0, 3, 3, 0, 1, 4};
        int xd[9] = '{0, 1, 1, 0, 1, 0, 0, 0, 0};
        for (int k = 0; k < 9; k++) begin
            start(3'(sl[k]), 2'(pm[k]), 1'b0, 3'h1);
            check(16'(ready_at >= mn[k]), 16'h0001);
            check(16'(active_select), 16'(ac[k]));
            check(16'(crystal_drive_en), 16'(xd[k]));
            measure();
            near(n_sys, rt[k]);
        end
    endtask
    task automatic sc_pin;
        start(3'h0, 2'h0, 1'b1, 3'h0);
        measure();
        check(16'(pin_oe), 16'h0001);
        check(16'(n_pin > 0), 16'h0001);
        start(3'h0, 2'h0, 1'b0, 3'h0);
        gpio_oe = 1'b1;
        for (int k = 0; k < 8; k++) begin
            gpio_out = k[0];
            @(posedge mclk);
            #1;
            check(16'({pin_oe, pin_o}), 16'({1'b1, k[0]}));
        end
        gpio_oe = 1'b0;
    endtask
    task automatic sc_hold;
        start(3'h6, 2'h0, 1'b0, 3'h0);
        cfg = '{3'h0, 1'b1, 2'h1, 3'h0};
        measure();
        near(n_sys, 20);
        check(16'(active_select), 16'h0006);
        check(16'(pin_oe), 16'h0000);
    endtask
    initial begin
        err_total = 0;
        n_checks = 0;
        reset = 1'b1;
        gpio_out = 1'b0;
        gpio_oe = 1'b0;
        cfg = '0;
        sc_internal();
        sc_sources();
        sc_pin();
        sc_hold();
        print_verdict();
    end
endmodule
bind oss_source_select oss_source_select_properties #(.LOCK_CYCLES(LOCK_CYCLES),
    .PERIOD_W(PERIOD_W)) u_props (.mclk(mclk), .reset(reset), .cfg(cfg),
    .src_ticks(src_ticks), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .sys_osc_tick(sys_osc_tick), .instruction_cycle_tick(instruction_cycle_tick),
    .clock_ready(clock_ready), .active_select(active_select),
    .crystal_drive_en(crystal_drive_en), .osc_output_pin_o(osc_output_pin_o),
    .osc_output_pin_oe(osc_output_pin_oe));
